// [core/cao_defs.vh]
// Register map, field positions and operation codes of the arithmetic unit
`ifndef CAO_DEFS_VH
`define CAO_DEFS_VH
// Register byte offsets
`define CAO_OFF_CTRL 12'h000
`define CAO_OFF_DEST 12'h004
`define CAO_OFF_SRC 12'h008
`define CAO_OFF_FLAGS 12'h00C
`define CAO_OFF_RES 12'h010
`define CAO_OFF_STAT 12'h014
// Control register field positions
`define CAO_OP_LSB 0
`define CAO_SGN_BIT 5
`define CAO_SZ_LSB 6
`define CAO_SRC_LSB 8
`define CAO_AMT_LSB 11
// Condition flag bit positions
`define CAO_FC 0
`define CAO_FV 1
`define CAO_FZ 2
`define CAO_FN 3
`define CAO_FH 5
// Reset values
`define CAO_CTRL_RST 32'h0000_0000
`define CAO_FLAGS_RST 8'h00
// Operand sizes
`define CAO_SZ_B 2'h0
`define CAO_SZ_W 2'h1
`define CAO_SZ_L 2'h2
// Source kinds
`define CAO_SRC_IMM 3'h0
`define CAO_SRC_REG 3'h1
`define CAO_SRC_IND 3'h2
`define CAO_SRC_PDEC 3'h3
`define CAO_SRC_MEM 3'h4
// Operation codes
`define CAO_OP_ADD 5'h00
`define CAO_OP_SUB 5'h01
`define CAO_OP_ADDC 5'h02
`define CAO_OP_SUBC 5'h03
`define CAO_OP_STUP 5'h04
`define CAO_OP_STDN 5'h05
`define CAO_OP_PTRP 5'h06
`define CAO_OP_PTRM 5'h07
`define CAO_OP_BCDA 5'h08
`define CAO_OP_BCDS 5'h09
`define CAO_OP_MULW 5'h0A
`define CAO_OP_MULL 5'h0B
`define CAO_OP_MULH 5'h0C
`define CAO_OP_DIVW 5'h0D
`define CAO_OP_DIVQ 5'h0E
`define CAO_OP_CMP 5'h0F
`define CAO_OP_NEG 5'h10
`define CAO_OP_ZEXT 5'h11
`endif

// [core/cao_arith.v]
// Arithmetic execution unit with an AXI4-Lite register slave
// Behaviour
// - Add and subtract byte, word, long; no byte register minus immediate byte.
// - Carry forms fold C in; memory source only indirect or post-decrement.
// - Step up or down by 1 or 2; byte only by 1.
// - Pointer offset add or subtract 1, 2 or 4 on longwords only.
// - Decimal adjust a byte sum or difference to two BCD digits using flags.
// - Widening multiply: 8x8 to 16 or 16x16 to 32, signed or not.
// - Low multiply keeps operand width: 16 or 32 bits.
// - High multiply returns upper 32 bits of a 32x32 product.
// - Widening divide: 16/8 or 32/16 giving quotient and remainder.
// - Same-width divide 16/16 or 32/32 gives quotient only.
// - Compare subtracts source from destination, updates flags only.
// - Negate replaces operand with zero minus operand.
// - Zero extend low 8 bits to word or long, or 16 to long.
// - Carry forms use the carry bit of the condition flags.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "cao_defs.vh"
module cao_arith #(
	parameter ADDR_W = 12
) (
	// Clock and reset
	input wire i_clock,
	input wire i_rst,
	// Write address channel
	input wire i_awvalid,
	output wire o_awready,
	input wire [ADDR_W-1:0] i_awaddr,
	// Write data channel
	input wire i_wvalid,
	output wire o_wready,
	input wire [31:0] i_wdata,
	input wire [3:0] i_wstrb,
	// Write response channel
	output reg o_bvalid,
	input wire i_bready,
	output reg [1:0] o_bresp,
	// Read address channel
	input wire i_arvalid,
	output wire o_arready,
	input wire [ADDR_W-1:0] i_araddr,
	// Read data channel
	output reg o_rvalid,
	input wire i_rready,
	output reg [31:0] o_rdata,
	output reg [1:0] o_rresp
);

	// Mask of a sized operand
	function [31:0] msk;
		input [1:0] sz;
		begin
			msk = (sz == `CAO_SZ_B) ? 32'h0000_00FF :
				(sz == `CAO_SZ_W) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
		end
	endfunction

	// Sign or zero extension of a sized operand to 33 bits
	function [32:0] ext;
		input [31:0] x;
		input [1:0] sz;
		input sgn;
		begin
			case (sz)
				`CAO_SZ_B: ext = {{25{sgn & x[7]}}, x[7:0]};
				`CAO_SZ_W: ext = {{17{sgn & x[15]}}, x[15:0]};
				default: ext = {sgn & x[31], x};
			endcase
		end
	endfunction

	reg [31:0] ctrl_reg, dest_reg, src_reg, res_reg;
	reg [7:0] flags_reg;
	reg [1:0] stat_reg;
	reg go_reg;
	reg aw_hold_reg, w_hold_reg;
	reg [ADDR_W-1:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;

	wire [4:0] op = ctrl_reg[`CAO_OP_LSB+4:`CAO_OP_LSB];
	wire sgn = ctrl_reg[`CAO_SGN_BIT];
	wire [1:0] sz = ctrl_reg[`CAO_SZ_LSB+1:`CAO_SZ_LSB];
	wire [2:0] srck = ctrl_reg[`CAO_SRC_LSB+2:`CAO_SRC_LSB];
	wire [1:0] amt = ctrl_reg[`CAO_AMT_LSB+1:`CAO_AMT_LSB];
	wire c_in = flags_reg[`CAO_FC];
	wire h_in = flags_reg[`CAO_FH];

	// Legality of the issued operation
	reg ill;
	always @* begin
		case (op)
			`CAO_OP_ADD, `CAO_OP_CMP, `CAO_OP_NEG: ill = (sz == 2'h3);
			`CAO_OP_SUB: ill = (sz == 2'h3) | ((sz == `CAO_SZ_B) & (srck == `CAO_SRC_IMM));
			`CAO_OP_ADDC, `CAO_OP_SUBC: ill = (sz == 2'h3) | (srck > `CAO_SRC_PDEC);
			`CAO_OP_STUP, `CAO_OP_STDN: ill = (sz == 2'h3) | (amt > 2'h1) |
				((sz == `CAO_SZ_B) & (amt != 2'h0));
			`CAO_OP_PTRP, `CAO_OP_PTRM: ill = (sz != `CAO_SZ_L) | (amt == 2'h3);
			`CAO_OP_BCDA, `CAO_OP_BCDS: ill = (sz != `CAO_SZ_B);
			`CAO_OP_MULW, `CAO_OP_DIVW: ill = (sz > `CAO_SZ_W);
			`CAO_OP_MULL, `CAO_OP_DIVQ: ill = (sz == `CAO_SZ_B) | (sz == 2'h3);
			`CAO_OP_MULH: ill = (sz != `CAO_SZ_L);
			`CAO_OP_ZEXT: ill = (sz == `CAO_SZ_B) | (sz == 2'h3) | (amt > 2'h1) |
				((amt == 2'h1) & (sz != `CAO_SZ_L));
			default: ill = 1'b1;
		endcase
	end

	// Shared adder operand selection
	reg [31:0] a_v, b_v;
	reg cin, sub;
	always @* begin
		a_v = dest_reg;
		b_v = src_reg;
		cin = 1'b0;
		sub = 1'b0;
		case (op)
			`CAO_OP_SUB, `CAO_OP_CMP: sub = 1'b1;
			`CAO_OP_ADDC: cin = c_in;
			`CAO_OP_SUBC: begin
				sub = 1'b1;
				cin = c_in;
			end
			`CAO_OP_STUP: b_v = (amt == 2'h0) ? 32'h0000_0001 : 32'h0000_0002;
			`CAO_OP_STDN: begin
				sub = 1'b1;
				b_v = (amt == 2'h0) ? 32'h0000_0001 : 32'h0000_0002;
			end
			`CAO_OP_NEG: begin
				sub = 1'b1;
				a_v = 32'h0000_0000;
				b_v = dest_reg;
			end
			default: ;
		endcase
	end

	// Width-aligned add or subtract so carry and sign sit at bits 32 and 31
	wire [4:0] sh = (sz == `CAO_SZ_B) ? 5'd24 : (sz == `CAO_SZ_W) ? 5'd16 : 5'd0;
	wire [32:0] a_al = {1'b0, a_v << sh};
	wire [32:0] b_al = {1'b0, b_v << sh};
	wire [32:0] c_al = {32'h0000_0000, cin} << sh;
	wire [32:0] s_al = sub ? (a_al - b_al - c_al) : (a_al + b_al + c_al);
	wire [31:0] r_add = s_al[31:0] >> sh;
	wire v_add = sub ? ((a_al[31] != b_al[31]) & (s_al[31] != a_al[31])) :
		((a_al[31] == b_al[31]) & (s_al[31] != a_al[31]));
	wire h_add = a_al[28] ^ b_al[28] ^ s_al[28];

	// Pointer offset by 1, 2 or 4 without flag effects
	wire [31:0] p_amt = 32'h0000_0001 << amt;
	wire [31:0] r_ptr = (op == `CAO_OP_PTRP) ? dest_reg + p_amt : dest_reg - p_amt;

	// Decimal adjust of the low byte
	wire [7:0] bv = dest_reg[7:0];
	wire lo_fix = h_in | (bv[3:0] > 4'h9);
	wire hi_fix = c_in | (bv > 8'h99);
	wire [7:0] bcd_k = {hi_fix ? 4'h6 : 4'h0, lo_fix ? 4'h6 : 4'h0};
	wire [7:0] bcd_a = bv + bcd_k;
	wire [7:0] bcd_s = bv - {c_in ? 4'h6 : 4'h0, h_in ? 4'h6 : 4'h0};

	// Single signed 33x33 multiplier serves every product form
	wire [1:0] mz = sz;
	wire signed [32:0] m_a = ext(dest_reg, mz, sgn);
	wire signed [32:0] m_b = ext(src_reg, mz, sgn);
	wire signed [65:0] m_p = m_a * m_b;

	// Divider on magnitudes with sign repair
	wire wide_div = (op == `CAO_OP_DIVW);
	wire [1:0] dz = wide_div ? sz + 2'h1 : sz;
	wire [32:0] d_n = ext(dest_reg, dz, sgn);
	wire [32:0] d_d = ext(src_reg, sz, sgn);
	wire n_neg = d_n[32];
	wire d_neg = d_d[32];
	wire [32:0] n_mag = n_neg ? 33'h0 - d_n : d_n;
	wire [32:0] d_mag = d_neg ? 33'h0 - d_d : d_d;
	wire div0 = ((op == `CAO_OP_DIVW) | (op == `CAO_OP_DIVQ)) & (d_mag == 33'h0);
	wire [32:0] q_mag = div0 ? 33'h0 : n_mag / d_mag;
	wire [32:0] r_mag = div0 ? 33'h0 : n_mag % d_mag;
	wire [31:0] q_v = (n_neg ^ d_neg) ? 32'h0 - q_mag[31:0] : q_mag[31:0];
	wire [31:0] r_v = n_neg ? 32'h0 - r_mag[31:0] : r_mag[31:0];

	// Result, write mask and flags for the operation
	reg [31:0] rv, wm;
	reg [7:0] fl;
	reg wr_res;
	always @* begin
		rv = r_add;
		wm = msk(sz);
		fl = flags_reg;
		wr_res = 1'b1;
		case (op)
			`CAO_OP_ADD, `CAO_OP_SUB, `CAO_OP_ADDC, `CAO_OP_SUBC, `CAO_OP_CMP,
			`CAO_OP_NEG: begin
				fl[`CAO_FN] = s_al[31];
				fl[`CAO_FV] = v_add;
				fl[`CAO_FC] = s_al[32];
				fl[`CAO_FH] = h_add;
				// Carry forms only clear Z, so multi-word results test as one
				fl[`CAO_FZ] = (r_add == 32'h0) &
					(((op != `CAO_OP_ADDC) & (op != `CAO_OP_SUBC)) | flags_reg[`CAO_FZ]);
				wr_res = (op != `CAO_OP_CMP);
			end
			`CAO_OP_STUP, `CAO_OP_STDN: begin
				fl[`CAO_FN] = s_al[31];
				fl[`CAO_FZ] = (r_add == 32'h0);
				fl[`CAO_FV] = v_add;
			end
			`CAO_OP_PTRP, `CAO_OP_PTRM: rv = r_ptr;
			`CAO_OP_BCDA, `CAO_OP_BCDS: begin
				rv = {24'h0, (op == `CAO_OP_BCDA) ? bcd_a : bcd_s};
				fl[`CAO_FN] = rv[7];
				fl[`CAO_FZ] = (rv[7:0] == 8'h0);
				if (op == `CAO_OP_BCDA)
					fl[`CAO_FC] = hi_fix;
			end
			`CAO_OP_MULW: begin
				rv = m_p[31:0];
				wm = msk(sz + 2'h1);
				fl[`CAO_FN] = (sz == `CAO_SZ_B) ? m_p[15] : m_p[31];
				fl[`CAO_FZ] = ((m_p[31:0] & wm) == 32'h0);
			end
			`CAO_OP_MULL, `CAO_OP_MULH: begin
				rv = (op == `CAO_OP_MULH) ? m_p[63:32] : m_p[31:0];
				fl[`CAO_FN] = (sz == `CAO_SZ_W) ? rv[15] : rv[31];
				fl[`CAO_FZ] = ((rv & wm) == 32'h0);
			end
			`CAO_OP_DIVW, `CAO_OP_DIVQ: begin
				// Quotient low, remainder above it for the widening form
				rv = wide_div ? ((r_v << ((sz == `CAO_SZ_B) ? 5'd8 : 5'd16)) |
					(q_v & wm)) : q_v;
				wm = wide_div ? msk(sz + 2'h1) : wm;
				fl[`CAO_FN] = (sz == `CAO_SZ_B) ? q_v[7] : (sz == `CAO_SZ_W) ? q_v[15] : q_v[31];
				fl[`CAO_FZ] = ((q_v & msk(sz)) == 32'h0);
				if (div0) begin
					fl = flags_reg;
					wr_res = 1'b0;
				end
			end
			`CAO_OP_ZEXT: begin
				rv = dest_reg & ((amt == 2'h0) ? 32'h0000_00FF : 32'h0000_FFFF);
				fl[`CAO_FN] = 1'b0;
				fl[`CAO_FV] = 1'b0;
				fl[`CAO_FZ] = (rv == 32'h0);
			end
			default: wr_res = 1'b0;
		endcase
	end

	// Write channel acceptance
	assign o_awready = ~aw_hold_reg & ~o_bvalid;
	assign o_wready = ~w_hold_reg & ~o_bvalid;
	wire aw_take = i_awvalid & o_awready;
	wire w_take = i_wvalid & o_wready;
	wire aw_have = aw_hold_reg | aw_take;
	wire w_have = w_hold_reg | w_take;
	wire [ADDR_W-1:0] wa = aw_hold_reg ? aw_addr_reg : i_awaddr;
	wire [31:0] wd = w_hold_reg ? w_data_reg : i_wdata;
	wire [3:0] ws = w_hold_reg ? w_strb_reg : i_wstrb;
	wire do_wr = aw_have & w_have & ~o_bvalid;
	wire [31:0] be = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
	wire wa_ok = (wa[ADDR_W-1:2] <= 3'd5) & (wa[1:0] == 2'b00) &
		(wa[ADDR_W-1:5] == {(ADDR_W-5){1'b0}});

	// Write handshake state and response
	always @(posedge i_clock) begin
		if (i_rst) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			aw_addr_reg <= {ADDR_W{1'b0}};
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			o_bvalid <= 1'b0;
			o_bresp <= 2'b00;
		end else begin
			if (aw_take) begin
				aw_addr_reg <= i_awaddr;
				aw_hold_reg <= ~w_have;
			end else if (do_wr)
				aw_hold_reg <= 1'b0;
			if (w_take) begin
				w_data_reg <= i_wdata;
				w_strb_reg <= i_wstrb;
				w_hold_reg <= ~aw_have;
			end else if (do_wr)
				w_hold_reg <= 1'b0;
			if (do_wr) begin
				o_bvalid <= 1'b1;
				o_bresp <= wa_ok ? 2'b00 : 2'b10;
			end else if (i_bready)
				o_bvalid <= 1'b0;
		end
	end

	// Register file and execution of issued operations
	always @(posedge i_clock) begin
		if (i_rst) begin
			ctrl_reg <= `CAO_CTRL_RST;
			dest_reg <= 32'h0;
			src_reg <= 32'h0;
			res_reg <= 32'h0;
			flags_reg <= `CAO_FLAGS_RST;
			stat_reg <= 2'b00;
			go_reg <= 1'b0;
		end else begin
			go_reg <= do_wr & (wa == `CAO_OFF_CTRL);
			if (do_wr) begin
				case (wa)
					`CAO_OFF_CTRL: ctrl_reg <= (ctrl_reg & ~be) | (wd & be);
					`CAO_OFF_DEST: dest_reg <= (dest_reg & ~be) | (wd & be);
					`CAO_OFF_SRC: src_reg <= (src_reg & ~be) | (wd & be);
					`CAO_OFF_FLAGS: if (ws[0]) flags_reg <= wd[7:0];
					default: ;
				endcase
			end
			if (go_reg) begin
				stat_reg <= {div0 & ~ill, ill};
				if (~ill) begin
					flags_reg <= fl;
					if (wr_res) begin
						res_reg <= (dest_reg & ~wm) | (rv & wm);
						dest_reg <= (dest_reg & ~wm) | (rv & wm);
					end else
						res_reg <= dest_reg;
				end
			end
		end
	end

	// Read channel
	assign o_arready = ~o_rvalid;
	wire ra_ok = (i_araddr[ADDR_W-1:2] <= 3'd5) & (i_araddr[1:0] == 2'b00) &
		(i_araddr[ADDR_W-1:5] == {(ADDR_W-5){1'b0}});
	reg [31:0] rd_v;
	always @* begin
		case (i_araddr)
			`CAO_OFF_CTRL: rd_v = ctrl_reg;
			`CAO_OFF_DEST: rd_v = dest_reg;
			`CAO_OFF_SRC: rd_v = src_reg;
			`CAO_OFF_FLAGS: rd_v = {24'h0, flags_reg};
			`CAO_OFF_RES: rd_v = res_reg;
			`CAO_OFF_STAT: rd_v = {29'h0, go_reg, stat_reg};
			default: rd_v = 32'h0;
		endcase
	end

	// Read data register
	always @(posedge i_clock) begin
		if (i_rst) begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0;
			o_rresp <= 2'b00;
		end else if (i_arvalid & o_arready) begin
			o_rvalid <= 1'b1;
			o_rdata <= rd_v;
			o_rresp <= ra_ok ? 2'b00 : 2'b10;
		end else if (i_rready)
			o_rvalid <= 1'b0;
	end

endmodule // cao_arith

// [sim/cao_arith_properties.sv]
// Bus handshake checker for the arithmetic unit
`timescale 1ns/1ns
module cao_arith_checker (
	// Clock and reset
	input wire i_clock,
	input wire i_rst,
	// Write side
	input wire i_awvalid,
	input wire o_awready,
	input wire i_wvalid,
	input wire o_wready,
	input wire o_bvalid,
	input wire i_bready,
	input wire [1:0] o_bresp,
	// Read side
	input wire i_arvalid,
	input wire o_arready,
	input wire o_rvalid,
	input wire i_rready,
	input wire [31:0] o_rdata,
	input wire [1:0] o_rresp
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// Answers follow the taken request by one cycle and stand until taken
	a_b_after_pair: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> o_bvalid)
		else $error("write response late");
	a_b_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped");
	a_b_drops: assert property (o_bvalid && i_bready |=> !o_bvalid)
		else $error("write response repeated");
	a_r_after_ar: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read data late");
	a_r_holds: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable({o_rdata, o_rresp}))
		else $error("read data changed");
	// Refusal while an answer is pending
	a_ar_refused: assert property (o_rvalid |-> !o_arready)
		else $error("read taken while busy");
	a_aw_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
		else $error("write taken while busy");
	// Error reads return zero data
	a_err_zero: assert property (o_rvalid && o_rresp != 2'h0 |-> o_rresp == 2'h2 && o_rdata == 32'h0)
		else $error("bad read error answer");
endmodule // cao_arith_checker
bind cao_arith cao_arith_checker u_cao_arith_checker (.i_clock(i_clock), .i_rst(i_rst),
	.i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
	.o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
	.o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
	.o_rresp(o_rresp));

// [sim/cao_axi_master.sv]
// Register bus master model with random ready delays
`timescale 1ns/1ns
module cao_axi_master (
	// Clock
	input wire i_clock,
	// Slave answers
	input wire i_awready,
	input wire i_wready,
	input wire i_bvalid,
	input wire [1:0] i_bresp,
	input wire i_arready,
	input wire i_rvalid,
	input wire [31:0] i_rdata,
	input wire [1:0] i_rresp,
	// Requests
	output reg o_awvalid = 1'b0,
	output reg [11:0] o_awaddr = 12'h000,
	output reg o_wvalid = 1'b0,
	output reg [31:0] o_wdata = 32'h0,
	output reg [3:0] o_wstrb = 4'h0,
	output reg o_bready = 1'b0,
	output reg o_arvalid = 1'b0,
	output reg [11:0] o_araddr = 12'h000,
	output reg o_rready = 1'b0
);
	// Address and data offered together, each released once taken
	task wr(input [11:0] a, input [31:0] d, output [1:0] r);
		reg a_ok;
		reg w_ok;
		a_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge i_clock);
		o_awvalid <= 1'b1;
		o_awaddr <= a;
		o_wvalid <= 1'b1;
		o_wdata <= d;
		o_wstrb <= 4'hF;
		while (!(a_ok && w_ok)) begin
			@(posedge i_clock);
			if (i_awready) a_ok = 1'b1;
			if (i_wready) w_ok = 1'b1;
			o_awvalid <= !a_ok;
			o_wvalid <= !w_ok;
		end
		repeat ($urandom % 3) @(posedge i_clock);
		o_bready <= 1'b1;
		do @(posedge i_clock); while (i_bvalid !== 1'b1);
		r = i_bresp;
		o_bready <= 1'b0;
	endtask
	// Read with a slow or prompt ready
	task rd(input [11:0] a, output [31:0] d, output [1:0] r);
		@(posedge i_clock);
		o_arvalid <= 1'b1;
		o_araddr <= a;
		do @(posedge i_clock); while (i_arready !== 1'b1);
		o_arvalid <= 1'b0;
		repeat ($urandom % 3) @(posedge i_clock);
		o_rready <= 1'b1;
		do @(posedge i_clock); while (i_rvalid !== 1'b1);
		d = i_rdata;
		r = i_rresp;
		o_rready <= 1'b0;
	endtask
endmodule // cao_axi_master

// [sim/tb_top.sv]
// Self-checking bench for the arithmetic unit
`timescale 1ns/1ns
module tb_top;
	reg i_clock = 1'b0;
	reg i_rst = 1'b1;
	wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	wire [11:0] awaddr, araddr;
	wire [31:0] wdata, rdata;
	wire [3:0] wstrb;
	wire [1:0] bresp, rresp;
	integer n_errors = 0, n_compared = 0, cycles = 0, i, j;
	reg [31:0] d, s, v, q, x, y;
	reg [63:0] p;
	reg [1:0] r;
	cao_arith u_cao_arith (.i_clock(i_clock), .i_rst(i_rst), .i_awvalid(awvalid),
		.o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
		.i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
		.i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
		.i_rready(rready), .o_rdata(rdata), .o_rresp(rresp));
	cao_axi_master u_cao_axi_master (.i_clock(i_clock), .i_awready(awready), .i_wready(wready),
		.i_bvalid(bvalid), .i_bresp(bresp), .i_arready(arready), .i_rvalid(rvalid),
		.i_rdata(rdata), .i_rresp(rresp), .o_awvalid(awvalid), .o_awaddr(awaddr),
		.o_wvalid(wvalid), .o_wdata(wdata), .o_wstrb(wstrb), .o_bready(bready),
		.o_arvalid(arvalid), .o_araddr(araddr), .o_rready(rready));
	initial forever #5 i_clock = ~i_clock;
	// Hang guard
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			n_errors = n_errors + 1;
			close_out;
		end
	end
	task close_out;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		n_compared = n_compared + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input [11:0] a, input [31:0] dv);
		u_cao_axi_master.wr(a, dv, r);
	endtask
	task rd(input [11:0] a);
		u_cao_axi_master.rd(a, v, r);
	endtask
	// Load operands, issue one operation, fetch status into q and result into v
	task t(input [4:0] o, input sg, input [1:0] sz, input [2:0] k, input [1:0] a,
		input [31:0] dv, input [31:0] sv, input [7:0] f, input [31:0] e);
		wr(12'h004, dv);
		wr(12'h008, sv);
		wr(12'h00C, {24'h0, f});
		wr(12'h000, {19'h0, a, k, sz, sg, o});
		rd(12'h014);
		q = v;
		rd(12'h010);
		chk(v, e);
	endtask
	// Expected N Z V C of a long subtraction
	function [3:0] cc(input [31:0] a, input [31:0] b);
		reg [32:0] w;
		begin
			w = {1'b0, a} - {1'b0, b};
			cc = {w[31], w[31:0] == 32'h0, (a[31] ^ b[31]) & (a[31] ^ w[31]), w[32]};
		end
	endfunction
	// Main sequence
	initial begin
		d = $urandom(18371);
		repeat (6) @(posedge i_clock);
		i_rst <= 1'b0;
		rd(12'h000);
		chk(v, 32'h0);
		rd(12'h00C);
		chk(v, 32'h0);
		rd(12'h020);
		chk({v[29:0], r}, 32'h2);
		wr(12'h024, d);
		chk({30'h0, r}, 32'h2);
		$display("reset and map test done");
		for (i = 0; i < 4; i = i + 1) begin
			d = $urandom;
			s = $urandom;
			t(5'h00, 0, 2, 1, 0, d, s, 0, d + s);
			t(5'h00, 0, 0, 0, 0, d, s, 0, {d[31:8], d[7:0] + s[7:0]});
			t(5'h01, 0, 1, 1, 0, d, s, 0, {d[31:16], d[15:0] - s[15:0]});
			t(5'h01, 0, 0, 0, 0, d, s, 0, v);
			chk(q & 32'h1, 32'h1);
			t(5'h02, 0, 2, 1, 0, d, s, 8'h01, d + s + 1);
			t(5'h03, 0, 0, 3, 0, d, s, 8'h01, {d[31:8], d[7:0] - s[7:0] - 8'h1});
			t(5'h02, 0, 2, 4, 0, d, s, 0, v);
			chk(q & 32'h1, 32'h1);
			t(5'h04, 0, 0, 1, 0, d, s, 0, {d[31:8], d[7:0] + 8'h1});
			t(5'h05, 0, 1, 1, 1, d, s, 0, {d[31:16], d[15:0] - 16'h2});
			t(5'h04, 0, 2, 1, 1, d, s, 0, d + 2);
			t(5'h06, 0, 2, 1, 2, d, s, 0, d + 4);
			for (j = 0; j < 3; j = j + 1) t(5'h07, 0, 2, 1, j[1:0], d, s, 0, d - (32'h1 << j));
			p = d[7:0] * s[7:0];
			t(5'h0A, 0, 0, 1, 0, d, s, 0, {d[31:16], p[15:0]});
			p = $signed(d[15:0]) * $signed(s[15:0]);
			t(5'h0A, 1, 1, 1, 0, d, s, 0, p[31:0]);
			p = d[15:0] * s[15:0];
			t(5'h0B, 0, 1, 1, 0, d, s, 0, {d[31:16], p[15:0]});
			t(5'h0B, 1, 2, 1, 0, d, s, 0, d * s);
			p = $signed(d) * $signed(s);
			t(5'h0C, 1, 2, 1, 0, d, s, 0, p[63:32]);
			p = {32'h0, d} * {32'h0, s};
			t(5'h0C, 0, 2, 1, 0, d, s, 0, p[63:32]);
			for (j = 0; j < 2; j = j + 1) begin
				y = j ? d : s;
				t(5'h0F, 0, 2, 1, 0, d, y, 0, d);
				rd(12'h00C);
				chk(v & 32'hF, {28'h0, cc(d, y)});
				rd(12'h004);
				chk(v, d);
			end
			t(5'h10, 0, 2, 1, 0, d, s, 0, 32'h0 - d);
			t(5'h10, 0, 0, 1, 0, d, s, 0, {d[31:8], 8'h0 - d[7:0]});
			t(5'h11, 0, 1, 1, 0, d, s, 0, {d[31:16], 8'h0, d[7:0]});
			t(5'h11, 0, 2, 1, 0, d, s, 0, {24'h0, d[7:0]});
			t(5'h11, 0, 2, 1, 1, d, s, 0, {16'h0, d[15:0]});
			t(5'h0E, 0, 2, 1, 0, d, s | 1, 0, d / (s | 1));
			t(5'h0E, 0, 2, 1, 0, d, 0, 0, d);
			chk(q & 32'h2, 32'h2);
			d = {1'b0, d[30:0]};
			s = {17'h1, s[14:0]};
			x = d / s;
			y = d % s;
			t(5'h0D, 0, 1, 1, 0, d, s, 0, {y[15:0], x[15:0]});
			$display("random pass %0d done", i);
		end
		t(5'h08, 0, 0, 1, 0, 32'hA5A5A50F, 0, 8'h00, 32'hA5A5A515);
		t(5'h09, 0, 0, 1, 0, 32'hA5A5A50F, 0, 8'h20, 32'hA5A5A509);
		t(5'h0D, 1, 0, 1, 0, 32'h0000FF9C, 32'h7, 0, 32'h0000FEF2);
		t(5'h0E, 1, 1, 1, 0, 32'h1234FF9C, 32'h7, 0, 32'h1234FFF2);
		$display("fixed case test done");
		close_out;
	end
endmodule // tb_top
